/* File: logic/spv_consts.svh */
/*
  Constants of the serial program/verify port: command codes, frame
  lengths, address map, reset values and timing.
  Assumes inclusion by bare name from the design files and the bench.
*/
`ifndef SPV_CONSTS_SVH
`define SPV_CONSTS_SVH

// command codes, defaults for the module parameters
`define SPV_CMD_LOAD_CONFIG 6'h00
`define SPV_CMD_LOAD_DATA 6'h02
`define SPV_CMD_READ_DATA 6'h04
`define SPV_CMD_INC_ADDR 6'h06

// frame lengths in programming clock edges
`define SPV_CMD_BITS 6
`define SPV_DATA_BITS 14

// address map
`define SPV_PC_RESET 14'h0000
`define SPV_ID_BASE 14'h2000
`define SPV_ID_COUNT 4
`define SPV_ID_BITS 4
`define SPV_PM_DEPTH 1024
`define SPV_BLANK_WORD 14'h3fff
`define SPV_PROTECT_WORD 14'h0000

// buffering
`define SPV_FIFO_DEPTH 32

// timing: clock period and programming pulse per word
`define SPV_CLK_PERIOD_NS 25
`define SPV_PROG_TIME_US 100
`define SPV_PROG_CYCLES \
  ((`SPV_PROG_TIME_US * 1000 + `SPV_CLK_PERIOD_NS - 1) / `SPV_CLK_PERIOD_NS)

`endif

/* File: logic/spv_pkg.sv */
/*
  Types of the serial program/verify port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package spv_pkg;

  typedef logic [13:0] spv_word_type;
  typedef logic [13:0] spv_addr_type;

  typedef enum logic [2:0] {
    SPV_IDLE,
    SPV_CMD,
    SPV_LOAD,
    SPV_PUSH,
    SPV_READ_WAIT,
    SPV_READ
  } spv_state_type;

endpackage

/* File: logic/spv_fifo.sv */
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module spv_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] writePtr;
  logic [AW-1:0] readPtr;
  logic [AW:0] count;

  wire doPush = inValid & inReady;
  wire doPop = outValid & outReady;

  assign inReady = count != (AW+1)'(DEPTH);
  assign outValid = count != '0;
  assign outData = store[readPtr];

  always_ff @(posedge ref_clk) begin
    if (doPush) begin
      store[writePtr] <= inData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      writePtr <= '0;
      readPtr <= '0;
      count <= '0;
    end else begin
      if (doPush) begin
        writePtr <= (writePtr == AW'(DEPTH - 1)) ? '0 : writePtr + 1'b1;
      end
      if (doPop) begin
        readPtr <= (readPtr == AW'(DEPTH - 1)) ? '0 : readPtr + 1'b1;
      end
      if (doPush & ~doPop) begin
        count <= count + 1'b1;
      end else if (doPop & ~doPush) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

/* File: logic/spv_port.sv */
/*
  Serial program/verify port of a small microcontroller: mode entry,
  command and data shifting, program memory, ID words, read-out gate.
  Assumes the master clear pin is seen as two levels (logic high, and
  a comparator flag for the programming high level) and that all pins
  are asynchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "spv_consts.svh"
module spv_port #(
  parameter logic [5:0] CMD_LOAD_CONFIG = `SPV_CMD_LOAD_CONFIG,
  parameter logic [5:0] CMD_LOAD_DATA = `SPV_CMD_LOAD_DATA,
  parameter logic [5:0] CMD_READ_DATA = `SPV_CMD_READ_DATA,
  parameter logic [5:0] CMD_INC_ADDR = `SPV_CMD_INC_ADDR,
  parameter bit LSB_FIRST = 1'b1,
  parameter bit SAMPLE_FALLING = 1'b1,
  parameter logic [13:0] PROTECT_WORD = `SPV_PROTECT_WORD,
  parameter int PM_DEPTH = `SPV_PM_DEPTH,
  parameter int FIFO_DEPTH = `SPV_FIFO_DEPTH,
  parameter int PROG_CYCLES = `SPV_PROG_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // master clear pin levels
  input wire logic masterClearPin,
  input wire logic programmingHighLevel,
  // serial programming pins
  input wire logic progClockPin,
  input wire logic progDataIn,
  output logic progDataOut,
  output logic progDataOe,
  // configuration
  input wire logic codeProtect,
  // status
  output logic progMode,
  output logic deviceResetLow,
  output logic progBusy
);

  localparam int PM_AW = $clog2(PM_DEPTH);
  localparam int FW = 28;
  localparam logic [3:0] CMD_LAST = 4'(`SPV_CMD_BITS - 1);
  localparam logic [3:0] DATA_LAST = 4'(`SPV_DATA_BITS - 1);
  localparam logic [15:0] PROG_LAST = 16'(PROG_CYCLES - 1);

  // bit order helpers
  function automatic spv_pkg::spv_word_type insertBit(
    input spv_pkg::spv_word_type word,
    input logic [3:0] index,
    input logic value
  );
    spv_pkg::spv_word_type result;
    result = word;
    if (LSB_FIRST) begin
      result[index] = value;
    end else begin
      result = {word[12:0], value};
    end
    return result;
  endfunction

  function automatic logic pickBit(
    input spv_pkg::spv_word_type word,
    input logic [3:0] index
  );
    logic [3:0] pos;
    pos = LSB_FIRST ? index : 4'(DATA_LAST - index);
    return word[pos];
  endfunction

  // pin synchronisers: {data, clock, high level, master clear}
  logic [3:0] pinMeta;
  logic [3:0] pinSync;
  logic clkPrev;
  logic highPrev;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pinMeta <= 4'h0;
      pinSync <= 4'h0;
      clkPrev <= 1'b0;
      highPrev <= 1'b0;
    end else begin
      pinMeta <= {progDataIn, progClockPin,
                  programmingHighLevel, masterClearPin};
      pinSync <= pinMeta;
      clkPrev <= pinSync[2];
      highPrev <= pinSync[1];
    end
  end

  wire mcLevel = pinSync[0];
  wire highLevel = pinSync[1];
  wire clkLevel = pinSync[2];
  wire dataLevel = pinSync[3];
  wire clkRise = clkLevel & ~clkPrev;
  wire clkFall = ~clkLevel & clkPrev;
  wire sampleEdge = SAMPLE_FALLING ? clkFall : clkRise;
  wire highRise = highLevel & ~highPrev;
  wire entryCond = highRise & mcLevel & ~clkLevel & ~dataLevel;

  // state
  spv_pkg::spv_state_type state;
  spv_pkg::spv_state_type next_state;
  spv_pkg::spv_addr_type pc;
  spv_pkg::spv_word_type inShift;
  spv_pkg::spv_word_type outShift;
  logic [3:0] bitCount;
  logic [15:0] progTimer;

  // memories
  logic [13:0] progMem [PM_DEPTH];
  logic [3:0] idMem [`SPV_ID_COUNT];

  // buffer between the shifter and the programming pulse
  logic fifoInReady;
  logic fifoOutValid;
  logic [FW-1:0] fifoOutData;

  wire fifoInValid = state == spv_pkg::SPV_PUSH;
  wire fifoOutReady = ~progBusy;
  wire doWrite = fifoOutValid & fifoOutReady;

  spv_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) wordFifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData({pc, inShift}),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // address decoding
  wire spv_pkg::spv_addr_type wrAddr = fifoOutData[27:14];
  wire spv_pkg::spv_word_type wrWord = fifoOutData[13:0];
  wire pcInPm = pc < 14'(PM_DEPTH);
  wire pcInId = pc[13:2] == `SPV_ID_BASE >> 2;
  wire wrInPm = wrAddr < 14'(PM_DEPTH);
  wire wrInId = wrAddr[13:2] == `SPV_ID_BASE >> 2;
  wire [PM_AW-1:0] pcIndex = pc[PM_AW-1:0];
  wire [PM_AW-1:0] wrIndex = wrAddr[PM_AW-1:0];

  // read-out gate
  wire spv_pkg::spv_word_type pmRead =
    codeProtect ? PROTECT_WORD : progMem[pcIndex];
  wire spv_pkg::spv_word_type idRead =
    {10'h000, idMem[pc[1:0]]};
  wire spv_pkg::spv_word_type readWord =
    pcInId ? idRead : (pcInPm ? pmRead : `SPV_BLANK_WORD);

  // shifting
  wire spv_pkg::spv_word_type next_inShift =
    insertBit(inShift, bitCount, dataLevel);
  wire [5:0] cmdCode = next_inShift[5:0];
  wire cmdDone = state == spv_pkg::SPV_CMD & sampleEdge
                 & bitCount == CMD_LAST;
  wire loadDone = state == spv_pkg::SPV_LOAD & sampleEdge
                  & bitCount == DATA_LAST;
  wire readDone = state == spv_pkg::SPV_READ & sampleEdge
                  & bitCount == DATA_LAST;
  wire readReady = state == spv_pkg::SPV_READ_WAIT
                   & ~fifoOutValid & ~progBusy;

  // command decode and sequencing
  always_comb begin
    next_state = state;
    case (state)
      spv_pkg::SPV_IDLE: begin
        if (entryCond) begin
          next_state = spv_pkg::SPV_CMD;
        end
      end
      spv_pkg::SPV_CMD: begin
        if (cmdDone) begin
          if (cmdCode == CMD_LOAD_DATA) begin
            next_state = spv_pkg::SPV_LOAD;
          end else if (cmdCode == CMD_READ_DATA) begin
            next_state = spv_pkg::SPV_READ_WAIT;
          end
        end
      end
      spv_pkg::SPV_LOAD: begin
        if (loadDone) begin
          next_state = spv_pkg::SPV_PUSH;
        end
      end
      spv_pkg::SPV_PUSH: begin
        if (fifoInReady) begin
          next_state = spv_pkg::SPV_CMD;
        end
      end
      spv_pkg::SPV_READ_WAIT: begin
        if (readReady) begin
          next_state = spv_pkg::SPV_READ;
        end
      end
      spv_pkg::SPV_READ: begin
        if (readDone) begin
          next_state = spv_pkg::SPV_CMD;
        end
      end
      default: begin
        next_state = spv_pkg::SPV_IDLE;
      end
    endcase
    if (~highLevel) begin
      next_state = spv_pkg::SPV_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= spv_pkg::SPV_IDLE;
      progMode <= 1'b0;
    end else begin
      state <= next_state;
      progMode <= next_state != spv_pkg::SPV_IDLE;
    end
  end

  // normal operation reset, held during programming
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      deviceResetLow <= 1'b0;
    end else begin
      deviceResetLow <= mcLevel & ~highLevel
                        & state == spv_pkg::SPV_IDLE;
    end
  end

  // program counter
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pc <= `SPV_PC_RESET;
    end else if (state == spv_pkg::SPV_IDLE) begin
      pc <= `SPV_PC_RESET;
    end else if (cmdDone & cmdCode == CMD_LOAD_CONFIG) begin
      pc <= `SPV_ID_BASE;
    end else if (cmdDone & cmdCode == CMD_INC_ADDR) begin
      pc <= pc + 14'h0001;
    end
  end

  // input shifter and bit counter
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      inShift <= 14'h0000;
      bitCount <= 4'h0;
    end else begin
      // last bit of a frame must land too, before the push
      if (sampleEdge & (state == spv_pkg::SPV_CMD
          | state == spv_pkg::SPV_LOAD)) begin
        inShift <= next_inShift;
      end
      if (cmdDone | loadDone | readDone | readReady
          | state == spv_pkg::SPV_IDLE) begin
        bitCount <= 4'h0;
      end else if (sampleEdge & (state == spv_pkg::SPV_CMD
                   | state == spv_pkg::SPV_LOAD
                   | state == spv_pkg::SPV_READ)) begin
        bitCount <= bitCount + 4'h1;
      end
    end
  end

  // data pin driver
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      outShift <= 14'h0000;
      progDataOut <= 1'b0;
      progDataOe <= 1'b0;
    end else if (~highLevel | readDone) begin
      progDataOe <= 1'b0;
    end else if (readReady) begin
      outShift <= readWord;
      progDataOut <= pickBit(readWord, 4'h0);
      progDataOe <= 1'b1;
    end else if (sampleEdge & state == spv_pkg::SPV_READ) begin
      progDataOut <= pickBit(outShift, bitCount + 4'h1);
    end
  end

  // programming pulse per drained word
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      progBusy <= 1'b0;
      progTimer <= 16'h0000;
    end else if (doWrite) begin
      progBusy <= 1'b1;
      progTimer <= PROG_LAST;
    end else if (progTimer != 16'h0000) begin
      progTimer <= progTimer - 16'h0001;
    end else begin
      progBusy <= 1'b0;
    end
  end

  // memory writes, only reachable through the mode
  always_ff @(posedge ref_clk) begin
    if (doWrite & wrInPm) begin
      progMem[wrIndex] <= wrWord;
    end
    if (doWrite & wrInId) begin
      idMem[wrAddr[1:0]] <= wrWord[3:0];
    end
  end

endmodule

/* File: verification/spv_port_properties.sv */
/*
  Pin-level assertions of the program/verify port.
  Assumes a bind into spv_port, one clock domain.
*/
`timescale 1ns/1ps
module spv_port_properties #(
  parameter int PROG_CYCLES = 4000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // master clear levels
  input wire logic masterClearPin,
  input wire logic programmingHighLevel,
  // serial pins
  input wire logic progClockPin,
  input wire logic progDataIn,
  input wire logic progDataOut,
  input wire logic progDataOe,
  // configuration and status
  input wire logic codeProtect,
  input wire logic progMode,
  input wire logic deviceResetLow,
  input wire logic progBusy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // length of the running programming pulse
  logic [15:0] busyLen;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busyLen <= 16'h0000;
    end else begin
      busyLen <= progBusy ? busyLen + 16'h0001 : 16'h0000;
    end
  end
  property p_entry;
    $rose(progMode) |-> programmingHighLevel && masterClearPin
      && !$past(progClockPin, 3) && !$past(progDataIn, 3);
  endproperty
  a_entry: assert property (p_entry)
    else $error("mode entered without entry levels");
  property p_exit;
    !programmingHighLevel [*5] |-> !progMode;
  endproperty
  a_exit: assert property (p_exit)
    else $error("mode kept after high level dropped");
  property p_core;
    progMode |-> !deviceResetLow;
  endproperty
  a_core: assert property (p_core)
    else $error("core running in program mode");
  property p_clear;
    !masterClearPin [*5] |-> !deviceResetLow;
  endproperty
  a_clear: assert property (p_clear)
    else $error("low master clear did not reset core");
  property p_drive;
    $rose(progDataOe) |-> progMode && !progBusy;
  endproperty
  a_drive: assert property (p_drive)
    else $error("data driven outside mode or while busy");
  property p_hold;
    $rose(progDataOe) |=> progDataOe [*8];
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data released early");
  property p_len;
    $rose(progDataOe) |-> ##[100:125] $fell(progDataOe);
  endproperty
  a_len: assert property (p_len)
    else $error("read frame not fourteen clocks long");
  property p_pulse;
    $fell(progBusy) |-> busyLen == PROG_CYCLES;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("programming pulse length wrong");
endmodule
bind spv_port spv_port_properties #(.PROG_CYCLES(PROG_CYCLES))
  i_spv_port_properties (
  .ref_clk(ref_clk), .reset(reset), .masterClearPin(masterClearPin),
  .programmingHighLevel(programmingHighLevel),
  .progClockPin(progClockPin), .progDataIn(progDataIn),
  .progDataOut(progDataOut), .progDataOe(progDataOe),
  .codeProtect(codeProtect), .progMode(progMode),
  .deviceResetLow(deviceResetLow), .progBusy(progBusy)
);

/* File: verification/spv_programmer.sv */
/*
  Behavioural external programmer: clock and data pins.
  Assumes pins change at falling ref_clk, 200 ns serial period.
*/
`timescale 1ns/1ps
module spv_programmer (
  // bench clock
  input wire logic ref_clk,
  // pins toward the device
  output logic progClockPin,
  output logic progDataIn,
  input wire logic progDataOut,
  input wire logic progDataOe
);
  logic drive;
  logic level;
  // released line shows the inverse of its last value
  assign progDataIn = progDataOe ? progDataOut : (drive ? level : ~level);
  initial begin
    progClockPin = 1'b0;
    drive = 1'b1;
    level = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic pins(input logic c, input logic d);
    progClockPin = c;
    level = d;
    drive = 1'b1;
  endtask
  // device samples on the falling edge, low bit first
  task automatic tick(input logic b);
    level = b;
    progClockPin = 1'b1;
    half();
    progClockPin = 1'b0;
    half();
  endtask
  task automatic cmd(input logic [5:0] c);
    drive = 1'b1;
    for (int i = 0; i < 6; i++) tick(c[i]);
  endtask
  task automatic data(input logic [13:0] v);
    for (int i = 0; i < 14; i++) tick(v[i]);
    drive = 1'b0;
  endtask
  task automatic recv(output logic [13:0] v, output logic ok);
    drive = 1'b0;
    ok = 1'b0;
    v = 14'h0000;
    for (int w = 0; w < 2000 && !ok; w++) begin
      @(negedge ref_clk);
      ok = (progDataOe === 1'b1);
    end
    for (int i = 0; i < 14; i++) begin
      progClockPin = 1'b1;
      half();
      v[i] = progDataIn;
      progClockPin = 1'b0;
      half();
    end
  endtask
endmodule

/* File: verification/spv_port_tb.sv */
/*
  Self-checking bench of the program/verify port.
  Assumes the programmer model and the bound checker.
*/
`timescale 1ns/1ps
`include "spv_consts.svh"
module spv_port_tb;
  logic ref_clk;
  logic reset;
  logic masterClearPin;
  logic programmingHighLevel;
  logic codeProtect;
  logic progClockPin, progDataIn, progDataOut, progDataOe;
  logic progMode, deviceResetLow, progBusy;
  logic [13:0] rd;
  logic ok;
  int n_mismatch;
  int n_compared;
  spv_port #(.PROTECT_WORD(14'h1234), .FIFO_DEPTH(4), .PROG_CYCLES(4))
    i_spv_port (
    .ref_clk(ref_clk), .reset(reset), .masterClearPin(masterClearPin),
    .programmingHighLevel(programmingHighLevel),
    .progClockPin(progClockPin), .progDataIn(progDataIn),
    .progDataOut(progDataOut), .progDataOe(progDataOe),
    .codeProtect(codeProtect), .progMode(progMode),
    .deviceResetLow(deviceResetLow), .progBusy(progBusy));
  spv_programmer i_spv_programmer (.ref_clk(ref_clk),
    .progClockPin(progClockPin), .progDataIn(progDataIn),
    .progDataOut(progDataOut), .progDataOe(progDataOe));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic check(input string what, input logic [13:0] seen,
                       input logic [13:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic enter();
    i_spv_programmer.pins(1'b0, 1'b0);
    cyc(4);
    programmingHighLevel = 1'b1;
    cyc(6);
    check("progMode", progMode, 1'b1);
    check("deviceResetLow", deviceResetLow, 1'b0);
  endtask
  task automatic leave();
    programmingHighLevel = 1'b0;
    cyc(6);
    check("progMode off", progMode, 1'b0);
  endtask
  task automatic wr(input logic [13:0] v);
    i_spv_programmer.cmd(`SPV_CMD_LOAD_DATA);
    i_spv_programmer.data(v);
    cyc(1);
    check("progBusy", progBusy, 1'b1);
  endtask
  task automatic rdchk(input string what, input logic [13:0] exp);
    i_spv_programmer.cmd(`SPV_CMD_READ_DATA);
    i_spv_programmer.recv(rd, ok);
    check("read ready", ok, 1'b1);
    check(what, rd, exp);
  endtask
  task automatic t_reset();
    cyc(4);
    check("core run", deviceResetLow, 1'b1);
    masterClearPin = 1'b0;
    cyc(5);
    check("core held", deviceResetLow, 1'b0);
    masterClearPin = 1'b1;
    cyc(5);
    $display("test reset done");
  endtask
  task automatic t_refuse();
    for (int k = 0; k < 2; k++) begin
      i_spv_programmer.pins(k == 0, k == 1);
      cyc(4);
      programmingHighLevel = 1'b1;
      cyc(8);
      check("refused entry", progMode, 1'b0);
      programmingHighLevel = 1'b0;
      cyc(4);
    end
    $display("test refuse done");
  endtask
  task automatic t_memory();
    enter();
    wr(14'h2a5c);
    rdchk("pm0", 14'h2a5c);
    i_spv_programmer.cmd(`SPV_CMD_INC_ADDR);
    wr(14'h15a3);
    rdchk("pm1", 14'h15a3);
    $display("test memory done");
  endtask
  task automatic t_id();
    i_spv_programmer.cmd(`SPV_CMD_LOAD_CONFIG);
    wr(14'h3ab5);
    rdchk("id0", 14'h0005);
    i_spv_programmer.cmd(`SPV_CMD_INC_ADDR);
    i_spv_programmer.cmd(`SPV_CMD_INC_ADDR);
    i_spv_programmer.cmd(`SPV_CMD_INC_ADDR);
    wr(14'h3ffa);
    rdchk("id3", 14'h000a);
    i_spv_programmer.cmd(`SPV_CMD_INC_ADDR);
    rdchk("past id", 14'h3fff);
    $display("test id done");
  endtask
  task automatic t_protect();
    leave();
    enter();
    rdchk("pm0 again", 14'h2a5c);
    codeProtect = 1'b1;
    rdchk("protected", 14'h1234);
    codeProtect = 1'b0;
    leave();
    $display("test protect done");
  endtask
  initial begin
    reset = 1'b1;
    masterClearPin = 1'b1;
    programmingHighLevel = 1'b0;
    codeProtect = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    cyc(8);
    reset = 1'b0;
    t_reset();
    t_refuse();
    t_memory();
    t_id();
    t_protect();
    complete_run();
  end
  // watchdog well beyond the expected run
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_mismatch++;
    complete_run();
  end
endmodule
